// [src/aprp_regs.svh]
// Purpose: constants of the converter parallel read and control port
// Assumes: one 200 MHz clock, control word written over the 16-bit data pins
// Notes:   bit positions and reset values of the write-only control word
`ifndef APRP_REGS_SVH
`define APRP_REGS_SVH

// control word, low byte of the data pins
`define APRP_CW_SELECT_BIT     7
`define APRP_CW_NAP_BIT        6
`define APRP_CW_SLEEP_BIT      5
`define APRP_CW_INVERT_BIT     4
`define APRP_CW_TAG_BIT        3
`define APRP_CW_RESET_N_BIT    3
`define APRP_CW_MODE_HI        2
`define APRP_CW_MODE_LO        0
`define APRP_CW_TRIG_HI        2
`define APRP_CW_TRIG_LO        0

// reset values of the stored control bits
`define APRP_CFG_NAP_RST       1'b0
`define APRP_CFG_SLEEP_RST     1'b0
`define APRP_CFG_INVERT_RST    1'b0
`define APRP_CFG_TAG_RST       1'b0
`define APRP_CFG_MODE_RST      3'h0
`define APRP_SOFT_RESET_N_RST  1'b1
`define APRP_SOFT_TRIG_N_RST   3'h7

// read modes and output formats
`define APRP_MODE_CYCLE        3'h6
`define APRP_MODE_QUEUE        3'h7
`define APRP_LAST_CHAN         3'h5
`define APRP_TAG_PREFIX        12'h800
`define APRP_NUM_CHAN          6
`define APRP_QUEUE_DEPTH       6
`define APRP_FIFO_DEPTH        16
`define APRP_ENTRY_WIDTH       19

`endif

// [src/aprp_pkg.sv]
// Purpose: types shared by the parallel read port, its checker and its bench
// Assumes: constants come from aprp_regs.svh
// Notes:   one entry is a channel code above a 16-bit result
`include "aprp_regs.svh"

package aprp_pkg;

    typedef logic [2:0]                     aprp_chan_t;
    typedef logic [15:0]                    aprp_word_t;
    typedef logic [`APRP_ENTRY_WIDTH-1:0]   aprp_entry_t;

    // read strobe position inside one channel's transfer
    typedef enum logic [1:0] {
        APRP_PH_FIRST,
        APRP_PH_SECOND,
        APRP_PH_THIRD
    } aprp_phase_e;

endpackage : aprp_pkg

// [src/aprp_result_fifo.sv]
// Purpose: result buffer between the conversion core and the read port
// Assumes: single clock, synchronous clear
// Notes:   read data come straight from the register array at the read pointer
`timescale 1ns/10ps
`include "aprp_regs.svh"

module aprp_result_fifo #(
    parameter int WIDTH = `APRP_ENTRY_WIDTH,
    parameter int DEPTH = `APRP_FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_clear,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // honest full and empty from the occupancy count
    assign o_in_ready  = (count_q != DEPTH[AW:0]);
    assign o_out_valid = (count_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_ptr_q];

    // storage array, written only on an accepted word
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_clear)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_clear)
        begin
            count_q <= '0;
        end
        else if (push && !pop)
        begin
            count_q <= count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_q <= count_q - 1'b1;
        end
    end

endmodule : aprp_result_fifo

// [src/aprp_port.sv]
// Purpose: parallel host read and control port of a six-channel sampling converter
// Assumes: host strobes and mode pins are asynchronous; results arrive on the I_CLK domain
// Notes:   every pin passes two flip-flops, so strobes must last several clock periods
`timescale 1ns/10ps
`include "aprp_regs.svh"

module aprp_port
    import aprp_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_CS_N,
    input  wire logic              I_RD_N,
    input  wire logic              I_WR_N,
    input  wire logic              I_BYTE_MODE,
    input  wire logic              I_TAG_ENABLE,
    input  wire logic              I_NAP,
    input  wire logic              I_MODE_SELECT_BIT0,
    input  wire logic              I_MODE_SELECT_BIT1,
    input  wire logic              I_MODE_SELECT_BIT2,
    input  wire logic              I_RESET_N,
    input  wire logic              I_SAMPLE_TRIGGER_PAIR_A_N,
    input  wire logic              I_SAMPLE_TRIGGER_PAIR_B_N,
    input  wire logic              I_SAMPLE_TRIGGER_PAIR_C_N,
    input  wire aprp_word_t        I_BUS,
    output aprp_word_t             O_BUS,
    output logic                   O_BUS_OE,
    input  wire logic              I_RESULT_VALID,
    output logic                   O_RESULT_READY,
    input  wire aprp_chan_t        I_RESULT_CHAN,
    input  wire aprp_word_t        I_RESULT_DATA,
    output logic [2:0]             O_CONV_START,
    output logic                   O_CORE_RESET,
    output logic                   O_NAP,
    output logic                   O_DEEP_SLEEP
);
    import aprp_pkg::*;

    localparam int PW = 29;

    // pin synchroniser: first stage read only by the second
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_meta_q;
    logic [PW-1:0] pin_q;

    assign pin_raw = {I_CS_N, I_RD_N, I_WR_N, I_BYTE_MODE, I_TAG_ENABLE, I_NAP,
                      I_MODE_SELECT_BIT2, I_MODE_SELECT_BIT1, I_MODE_SELECT_BIT0, I_RESET_N,
                      I_SAMPLE_TRIGGER_PAIR_A_N, I_SAMPLE_TRIGGER_PAIR_B_N,
                      I_SAMPLE_TRIGGER_PAIR_C_N, I_BUS};

    always_ff @(posedge I_CLK)
    begin
        pin_meta_q <= pin_raw;
        pin_q      <= pin_meta_q;
    end

    logic       cs_n_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic       byte_s;
    logic       tag_pin_s;
    logic       nap_pin_s;
    aprp_chan_t mode_pin_s;
    logic       reset_n_pin_s;
    logic [2:0] trig_pin_n_s;
    aprp_word_t bus_s;

    assign {cs_n_s, rd_n_s, wr_n_s, byte_s, tag_pin_s, nap_pin_s, mode_pin_s,
            reset_n_pin_s, trig_pin_n_s, bus_s} = pin_q;

    // strobe edges on the synchronised levels
    logic rd_act;
    logic wr_act;
    logic rd_act_q;
    logic wr_act_q;
    logic rd_fall;
    logic rd_rise;
    logic wr_done;

    assign rd_act  = !cs_n_s && !rd_n_s;
    assign wr_act  = !cs_n_s && !wr_n_s;
    assign rd_fall = rd_act && !rd_act_q;
    assign rd_rise = !rd_act && rd_act_q;
    assign wr_done = !wr_act && wr_act_q;

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    // stored control word; device reset clears it, so a soft reset lasts one cycle
    logic       cfg_nap_q;
    logic       cfg_sleep_q;
    logic       cfg_invert_q;
    logic       cfg_tag_q;
    aprp_chan_t cfg_mode_q;
    logic       soft_reset_n_q;
    logic [2:0] soft_trig_n_q;
    logic       dev_reset;

    assign dev_reset = I_RST || !reset_n_pin_s || !soft_reset_n_q;

    // data are taken as the write strobe ends, when the pins have settled
    always_ff @(posedge I_CLK)
    begin
        if (dev_reset)
        begin
            cfg_nap_q      <= `APRP_CFG_NAP_RST;
            cfg_sleep_q    <= `APRP_CFG_SLEEP_RST;
            cfg_invert_q   <= `APRP_CFG_INVERT_RST;
            cfg_tag_q      <= `APRP_CFG_TAG_RST;
            cfg_mode_q     <= `APRP_CFG_MODE_RST;
            soft_reset_n_q <= `APRP_SOFT_RESET_N_RST;
            soft_trig_n_q  <= `APRP_SOFT_TRIG_N_RST;
        end
        else if (wr_done && bus_s[`APRP_CW_SELECT_BIT])
        begin
            cfg_nap_q    <= bus_s[`APRP_CW_NAP_BIT];
            cfg_sleep_q  <= bus_s[`APRP_CW_SLEEP_BIT];
            cfg_invert_q <= bus_s[`APRP_CW_INVERT_BIT];
            cfg_tag_q    <= bus_s[`APRP_CW_TAG_BIT];
            cfg_mode_q   <= bus_s[`APRP_CW_MODE_HI:`APRP_CW_MODE_LO];
        end
        else if (wr_done)
        begin
            soft_reset_n_q <= bus_s[`APRP_CW_RESET_N_BIT];
            soft_trig_n_q  <= bus_s[`APRP_CW_TRIG_HI:`APRP_CW_TRIG_LO];
        end
    end

    // power modes: nap has a pin, deep sleep has none
    assign O_NAP        = nap_pin_s || cfg_nap_q;
    assign O_DEEP_SLEEP = cfg_sleep_q;
    assign O_CORE_RESET = dev_reset;

    // triggers: pin and bit low-active combined; falling edge starts the pair
    logic [2:0] trig_n;
    logic [2:0] trig_n_q;

    assign trig_n = trig_pin_n_s & soft_trig_n_q;  // both ordered pair A, B, C from bit 2 down

    always_ff @(posedge I_CLK)
    begin
        if (dev_reset)
        begin
            trig_n_q     <= 3'h7;
            O_CONV_START <= 3'h0;
        end
        else
        begin
            trig_n_q     <= trig_n;
            O_CONV_START <= trig_n_q & ~trig_n;
        end
    end

    // effective read settings; mode held by the latch from the read start
    logic       tag_eff;
    aprp_chan_t mode_now;
    aprp_chan_t mode_q;
    logic       seq_mode;
    logic       queue_mode;

    assign tag_eff    = tag_pin_s || cfg_tag_q;
    assign mode_now   = rd_fall ? (mode_pin_s | cfg_mode_q) : mode_q;
    assign seq_mode   = (mode_now == `APRP_MODE_CYCLE) || (mode_now == `APRP_MODE_QUEUE);
    assign queue_mode = (mode_now == `APRP_MODE_QUEUE);

    always_ff @(posedge I_CLK)
    begin
        if (dev_reset)
        begin
            mode_q <= `APRP_CFG_MODE_RST;
        end
        else if (rd_fall)
        begin
            mode_q <= mode_now;
        end
    end

    // result buffer in front of the store; stalls the core when full
    aprp_entry_t fifo_data;
    logic        fifo_valid;
    logic        pop_head;
    logic        store_ok;
    logic        store;
    aprp_chan_t  new_chan;
    aprp_word_t  new_data;

    aprp_result_fifo #(
        .WIDTH (`APRP_ENTRY_WIDTH),
        .DEPTH (`APRP_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_rst       (I_RST),
        .i_clear     (dev_reset),
        .i_in_valid  (I_RESULT_VALID),
        .o_in_ready  (O_RESULT_READY),
        .i_in_data   ({I_RESULT_CHAN, I_RESULT_DATA}),
        .o_out_valid (fifo_valid),
        .i_out_ready (store_ok),
        .o_out_data  (fifo_data)
    );

    // no store during a read, nor while the head is being dropped
    assign store_ok = !rd_act && !rd_act_q && !dev_reset;
    assign store    = store_ok && fifo_valid;
    assign {new_chan, new_data} = fifo_data;

    // per-channel result registers for direct and cycle reads
    aprp_word_t              chan_data_q [`APRP_NUM_CHAN];
    logic [`APRP_NUM_CHAN-1:0] chan_full_q;

    // queue entries, entry zero is the oldest
    aprp_entry_t ent_q [`APRP_QUEUE_DEPTH];
    logic [2:0]  count_q;
    logic        q_full;

    assign q_full = (count_q == 3'(`APRP_QUEUE_DEPTH));

    genvar gi;
    generate
        for (gi = 0; gi < `APRP_NUM_CHAN; gi++)
        begin : g_entry
            // channel register follows the latest result of its channel
            always_ff @(posedge I_CLK)
            begin
                if (dev_reset)
                begin
                    chan_data_q[gi] <= 16'h0000;
                    chan_full_q[gi] <= 1'b0;
                end
                else if (store && (new_chan == 3'(gi)))
                begin
                    chan_data_q[gi] <= new_data;
                    chan_full_q[gi] <= 1'b1;
                end
            end

            // queue slot: shift down on drop or overflow, else fill the next free slot
            always_ff @(posedge I_CLK)
            begin
                if (dev_reset)
                begin
                    ent_q[gi] <= '0;
                end
                else if (store && q_full)
                begin
                    ent_q[gi] <= (gi == `APRP_QUEUE_DEPTH - 1) ? fifo_data
                                                                : ent_q[(gi + 1) % `APRP_QUEUE_DEPTH];
                end
                else if (store && (count_q == 3'(gi)))
                begin
                    ent_q[gi] <= fifo_data;
                end
                else if (pop_head)
                begin
                    ent_q[gi] <= (gi == `APRP_QUEUE_DEPTH - 1) ? '0
                                                                : ent_q[(gi + 1) % `APRP_QUEUE_DEPTH];
                end
            end
        end
    endgenerate

    // queue occupancy; store and drop never share a cycle
    always_ff @(posedge I_CLK)
    begin
        if (dev_reset)
        begin
            count_q <= 3'h0;
        end
        else if (store && !q_full)
        begin
            count_q <= count_q + 3'h1;
        end
        else if (pop_head)
        begin
            count_q <= count_q - 3'h1;
        end
    end

    // read strobe counter and channel pointer
    aprp_phase_e phase_q;
    aprp_chan_t  cyc_ptr_q;
    logic        dummy_pend_q;
    logic [1:0]  last_phase;
    logic        at_last;

    // direct codes ignore tagging
    always_comb
    begin
        if (seq_mode && tag_eff)
        begin
            last_phase = byte_s ? 2'h2 : 2'h1;
        end
        else
        begin
            last_phase = byte_s ? 2'h1 : 2'h0;
        end
    end

    assign at_last  = (2'(phase_q) >= last_phase);
    assign pop_head = rd_rise && queue_mode && !dummy_pend_q && at_last && (count_q != 3'h0);

    // counter advances as each read ends; the first queue read after reset is a dummy
    always_ff @(posedge I_CLK)
    begin
        if (dev_reset)
        begin
            phase_q      <= APRP_PH_FIRST;
            cyc_ptr_q    <= 3'h0;
            dummy_pend_q <= 1'b1;
        end
        else if (rd_rise && queue_mode && dummy_pend_q)
        begin
            dummy_pend_q <= 1'b0;
        end
        else if (rd_rise && at_last)
        begin
            phase_q <= APRP_PH_FIRST;
            if (mode_now == `APRP_MODE_CYCLE)
            begin
                cyc_ptr_q <= (cyc_ptr_q == `APRP_LAST_CHAN) ? 3'h0 : cyc_ptr_q + 3'h1;
            end
        end
        else if (rd_rise)
        begin
            case (phase_q)
                APRP_PH_FIRST:  phase_q <= APRP_PH_SECOND;
                APRP_PH_SECOND: phase_q <= APRP_PH_THIRD;
                default:        phase_q <= APRP_PH_FIRST;
            endcase
        end
    end

    // selected result, its channel code and valid flag
    aprp_chan_t sel_chan;
    aprp_word_t sel_data;
    logic       sel_valid;
    aprp_word_t out_word;

    always_comb
    begin
        if (queue_mode)
        begin
            sel_valid = (count_q != 3'h0);
            sel_chan  = sel_valid ? ent_q[0][18:16] : 3'h0;
            sel_data  = sel_valid ? ent_q[0][15:0] : 16'h0000;
        end
        else
        begin
            sel_chan  = (mode_now == `APRP_MODE_CYCLE) ? cyc_ptr_q : mode_now;
            sel_valid = chan_full_q[sel_chan];
            sel_data  = chan_data_q[sel_chan];
        end
        // empty queue words stay all zero, even with inversion on
        if (sel_valid || !queue_mode)
        begin
            sel_data[15] = sel_data[15] ^ cfg_invert_q;
        end
    end

    // word for the current strobe; a byte shows on both lanes
    always_comb
    begin
        out_word = 16'h0000;
        if (seq_mode && tag_eff)
        begin
            case (phase_q)
                APRP_PH_FIRST:
                begin
                    if (byte_s)
                    begin
                        out_word = {2{sel_valid, sel_chan, sel_data[3:0]}};
                    end
                    else
                    begin
                        out_word = {`APRP_TAG_PREFIX, sel_valid, sel_chan};
                    end
                end
                APRP_PH_SECOND: out_word = byte_s ? {2{sel_data[7:0]}} : sel_data;
                APRP_PH_THIRD:  out_word = {2{sel_data[15:8]}};
                default:        out_word = 16'h0000;
            endcase
        end
        else
        begin
            case (phase_q)
                APRP_PH_FIRST:  out_word = byte_s ? {2{sel_data[7:0]}} : sel_data;
                APRP_PH_SECOND: out_word = {2{sel_data[15:8]}};
                default:        out_word = 16'h0000;
            endcase
        end
        if (queue_mode && !sel_valid)
        begin
            out_word = 16'h0000;
        end
    end

    // output word loaded as each read begins and held for the whole strobe
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            O_BUS <= 16'h0000;
        end
        else if (rd_fall)
        begin
            O_BUS <= out_word;
        end
    end

    // pins driven only while read and chip select are both active
    assign O_BUS_OE = rd_act && rd_act_q;

endmodule : aprp_port

// [dv/aprp_port_properties.sv]
// Purpose: port properties of the read and control port
// Assumes: one clock, I_RST synchronous
// Notes:   pins pass two flops, windows allow that slack
`timescale 1ns/10ps
module aprp_port_checker
    import aprp_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_RST,
    input wire logic       I_CS_N,
    input wire logic       I_RD_N,
    input wire logic       I_NAP,
    input wire logic       I_RESET_N,
    input wire logic       I_SAMPLE_TRIGGER_PAIR_A_N,
    input wire aprp_word_t O_BUS,
    input wire logic       O_BUS_OE,
    input wire logic       O_RESULT_READY,
    input wire logic [2:0] O_CONV_START,
    input wire logic       O_CORE_RESET,
    input wire logic       O_NAP
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // output enable follows the combined strobe
    a_read_drives_bus: assert property ((!I_CS_N && !I_RD_N) [*4] |-> O_BUS_OE)
        else $error("bus idle during read");
    a_idle_bus_off: assert property (I_CS_N [*4] |-> !O_BUS_OE)
        else $error("bus driven while deselected");
    // data change only at a read start, past reset a stale value is fine
    a_bus_holds_idle: assert property (I_RD_N && $past(I_RD_N) && $past(I_RD_N, 2) |-> $stable(O_BUS))
        else $error("bus changed without read");
    a_pin_reset_core: assert property (!I_RESET_N [*4] |-> O_CORE_RESET)
        else $error("pin reset not applied");
    a_trig_starts_pair: assert property ($fell(I_SAMPLE_TRIGGER_PAIR_A_N) && !O_CORE_RESET
        |-> ##[1:5] O_CONV_START[2])
        else $error("trigger gave no start");
    a_start_one_cycle: assert property (|O_CONV_START |=> O_CONV_START == 3'h0)
        else $error("start pulse too long");
    a_nap_from_pin: assert property (I_NAP [*3] |-> O_NAP)
        else $error("nap pin ignored");
    a_reset_release_clean: assert property ($fell(I_RST) |-> O_CONV_START == 3'h0 && O_RESULT_READY)
        else $error("dirty state after reset");
endmodule : aprp_port_checker

// [dv/aprp_host_model.sv]
// Purpose: host processor on the read and control pins
// Assumes: strobes long enough for the two-flop pin sync
// Notes:   released data pins show the inverse of the last write
`timescale 1ns/10ps
module aprp_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic             o_cs_n,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic      [15:0] o_wdata
);
    initial {o_cs_n, o_rd_n, o_wr_n, o_wdata} = {3'h7, 16'h0};
    // one read: low five edges, take data, high again three
    task automatic rd(output logic [15:0] d);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        d = i_rdata;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask : rd
    // control word on the low byte, held past the synced strobe end
    task automatic wr(input logic [7:0] v);
        @(posedge i_clk);
        o_cs_n  <= 1'b0;
        o_wr_n  <= 1'b0;
        o_wdata <= {8'h00, v};
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_wdata <= ~o_wdata;
    endtask : wr
    // stall: keep a read open to hold results back
    task automatic hold(input logic low);
        @(posedge i_clk);
        o_cs_n <= !low;
        o_rd_n <= !low;
    endtask : hold
endmodule : aprp_host_model

// [dv/tb.sv]
// Purpose: self-checking bench of the read and control port
// Assumes: host model makes strobes, bench drives pins and results
// Notes:   trigger pins idle high as for software control, pulsed by the bench
`timescale 1ns/10ps
module tb;
    import aprp_pkg::*;
    logic       clk, rst, byte_m, tag_en, nap, rst_pin_n, trig_a_n, trig_b_n, trig_c_n, res_v, clr;
    logic       cs_n, rd_n, wr_n, oe, rdy, core_rst, nap_o, sleep;
    logic [2:0] mode, start, seen;
    aprp_chan_t res_ch;
    aprp_word_t res_d, wdata, rdata;
    int         err_total = 0, samples_checked = 0, cyc = 0;
    aprp_port i_dut (.I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_RD_N(rd_n), .I_WR_N(wr_n),
        .I_BYTE_MODE(byte_m), .I_TAG_ENABLE(tag_en), .I_NAP(nap), .I_MODE_SELECT_BIT0(mode[0]),
        .I_MODE_SELECT_BIT1(mode[1]), .I_MODE_SELECT_BIT2(mode[2]), .I_RESET_N(rst_pin_n),
        .I_SAMPLE_TRIGGER_PAIR_A_N(trig_a_n), .I_SAMPLE_TRIGGER_PAIR_B_N(trig_b_n),
        .I_SAMPLE_TRIGGER_PAIR_C_N(trig_c_n), .I_BUS(wdata), .O_BUS(rdata), .O_BUS_OE(oe),
        .I_RESULT_VALID(res_v), .O_RESULT_READY(rdy), .I_RESULT_CHAN(res_ch), .I_RESULT_DATA(res_d),
        .O_CONV_START(start), .O_CORE_RESET(core_rst), .O_NAP(nap_o), .O_DEEP_SLEEP(sleep));
    aprp_host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_cs_n(cs_n), .o_rd_n(rd_n),
        .o_wr_n(wr_n), .o_wdata(wdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // start pulses gathered so short pulses are not missed
    always @(posedge clk) seen <= clr ? 3'h0 : seen | start;
    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [15:0] exp);
        logic [15:0] v;
        i_host.rd(v);
        chk(v, exp);
    endtask : rdc
    task automatic push(input aprp_chan_t ch, input aprp_word_t v);
        @(posedge clk);
        res_v  <= 1'b1;
        res_ch <= ch;
        res_d  <= v;
        @(negedge clk);
        while (!rdy) @(negedge clk);
        @(posedge clk);
        res_v <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : push
    task automatic pin_reset();
        @(posedge clk);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pin_reset
    task automatic t_cycle();
        mode   <= 3'h6;
        tag_en <= 1'b1;
        push(3'h0, 16'h1234);
        rdc(16'h8008);
        rdc(16'h1234);
        rdc(16'h8001);
        rdc(16'h0000);
        byte_m <= 1'b1;
        rdc(16'h2020);
        byte_m <= 1'b0;
    endtask : t_cycle
    task automatic t_queue();
        pin_reset();
        mode <= 3'h7;
        rdc(16'h0000);
        push(3'h4, 16'h0c0c);
        push(3'h5, 16'h0d0d);
        rdc(16'h800c);
        rdc(16'h0c0c);
        rdc(16'h800d);
        rdc(16'h0d0d);
        rdc(16'h0000);
        rdc(16'h0000);
    endtask : t_queue
    task automatic t_direct();
        mode <= 3'h0;
        push(3'h0, 16'h1234);
        rdc(16'h1234);
        byte_m <= 1'b1;
        rdc(16'h3434);
        rdc(16'h1212);
        byte_m <= 1'b0;
        i_host.wr(8'h90);
        rdc(16'h9234);
        i_host.wr(8'h85);
        rdc(16'h0d0d);
        i_host.wr(8'h80);
    endtask : t_direct
    // open read stalls the buffer until it refuses, then overflow drops oldest
    task automatic t_fill();
        int n;
        n = 0;
        pin_reset();
        mode   <= 3'h7;
        tag_en <= 1'b0;
        i_host.hold(1'b1);
        repeat (4) @(posedge clk);
        res_v  <= 1'b1;
        res_ch <= 3'h0;
        res_d  <= 16'h0;
        repeat (24)
        begin
            @(negedge clk);
            n += int'(rdy);
            @(posedge clk);
            res_d <= 16'(n);
        end
        res_v <= 1'b0;
        chk(16'(n), 16'h0010);
        i_host.hold(1'b0);
        repeat (60) @(posedge clk);
        rdc(16'h000a);
        rdc(16'h000b);
    endtask : t_fill
    task automatic t_ctrl();
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            i_host.wr(8'h0f ^ 8'(1 << k));
            repeat (4) @(posedge clk);
            chk({13'h0, seen}, 16'(1 << k));
        end
        i_host.wr(8'h0f);
        clr      <= 1'b1;
        @(posedge clk);
        clr      <= 1'b0;
        {trig_a_n, trig_b_n, trig_c_n} <= 3'h0;
        repeat (6) @(posedge clk);
        {trig_a_n, trig_b_n, trig_c_n} <= 3'h7;
        chk({13'h0, seen}, 16'h0007);
        i_host.wr(8'he0);
        chk({14'h0, nap_o, sleep}, 16'h0003);
        // soft reset with every trigger bit low: reset wins, no start
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        i_host.wr(8'h00);
        repeat (4) @(posedge clk);
        chk({11'h0, seen, nap_o, sleep}, 16'h0000);
        i_host.wr(8'h80);
        chk({14'h0, nap_o, sleep}, 16'h0000);
        nap <= 1'b1;
        repeat (4) @(posedge clk);
        chk({15'h0, nap_o}, 16'h0001);
        nap <= 1'b0;
    endtask : t_ctrl
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {rst, byte_m, tag_en, nap, mode, res_v, clr} = {1'b1, 8'h0};
        {rst_pin_n, trig_a_n, trig_b_n, trig_c_n, res_ch, res_d} = {4'hf, 19'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_cycle();
        t_queue();
        t_direct();
        t_fill();
        t_ctrl();
        report_and_stop();
    end
endmodule : tb
bind aprp_port aprp_port_checker u_chk (.*);
